/* File: src/usl_pkg.sv */
package usl_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CR = 8'h00;
    localparam logic [7:0] OFS_MR = 8'h04;
    localparam logic [7:0] OFS_CSR = 8'h14;
    localparam logic [7:0] OFS_RHR = 8'h18;
    localparam logic [7:0] OFS_FIDI = 8'h40;
    localparam logic [7:0] OFS_IF = 8'h4c;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MR_MODE_LSB = 0;
    localparam int MR_CHMODE_LSB = 14;
    localparam int MR_NACK_INHIBIT = 20;
    localparam int MR_LIMIT_NACK_ENABLE = 21;
    localparam int MR_MAXIT_LSB = 24;
    localparam int CR_RSTSTA = 8;
    localparam int CR_RSTIT = 13;
    localparam int CR_CLEAR_NACK_CMD = 14;
    localparam int CR_DTR_ENABLE_CMD = 16;
    localparam int CR_DTR_DISABLE_CMD = 17;
    localparam int CSR_RX_READY_FLAG = 0;
    localparam int CSR_PARITY_ERROR_FLAG = 7;
    localparam int CSR_TX_EMPTY_FLAG = 9;
    localparam int CSR_ITER = 10;
    localparam int CSR_NACK = 13;
    localparam int CSR_RI_CHANGE_FLAG = 16;
    localparam int CSR_CTS_CHANGE_FLAG = 19;
    localparam int CSR_RI = 20;
    localparam int CSR_CTS = 23;
    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [10:0] FIDI_RST = 11'h174;
    localparam logic [7:0] IF_RST = 8'h00;
    localparam logic DTR_RST = 1'b1;
    localparam int OVERSAMPLE = 16;
    localparam int IR_PULSE_NUM = 3;
    localparam int IR_PULSE_TICKS = OVERSAMPLE * IR_PULSE_NUM / 16;
    // ------------------------------------------------------------
    // modes and carriers
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_NORMAL = 4'h0,
        MODE_RS485 = 4'h1,
        MODE_HANDSHAKE = 4'h2,
        MODE_MODEM = 4'h3,
        MODE_ISO_T0 = 4'h4,
        MODE_ISO_T1 = 4'h6,
        MODE_INFRA = 4'h8
    } usl_line_e;
    typedef enum logic [1:0] {
        CH_NORMAL = 2'h0,
        CH_ECHO = 2'h1,
        CH_LOCAL = 2'h2,
        CH_REMOTE = 2'h3
    } usl_chan_e;
    typedef struct packed {
        logic valid;
        logic parErr;
        logic [7:0] data;
    } usl_rxev_s;
    typedef struct packed {
        logic nack;
        logic ack;
    } usl_txev_s;
endpackage : usl_pkg

/* File: src/usl_ir_mod.sv */
`timescale 1ns/1ps
module usl_ir_mod (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // core transmitter timing
    input wire logic sampleTick,
    input wire logic bitStart,
    input wire logic txBit,
    // modulated pulse, high while light is on
    output logic pulse
);
    localparam logic [4:0] PULSE_LEN = 5'(usl_pkg::IR_PULSE_TICKS);
    logic [4:0] cnt_reg;

    // zero bit starts a 3/16 pulse, one bit none
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            cnt_reg <= 5'h00;
        else if (bitStart)
            cnt_reg <= txBit ? 5'h00 : PULSE_LEN;
        else if (sampleTick && cnt_reg != 5'h00)
            cnt_reg <= cnt_reg - 5'h01;
    end

    assign pulse = (cnt_reg != 5'h00);
endmodule : usl_ir_mod

/* File: src/usl_ir_demod.sv */
`timescale 1ns/1ps
module usl_ir_demod #(
    parameter int FILTER_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // line and settings
    input wire logic sampleTick,
    input wire logic rxLine,
    input wire logic [FILTER_W-1:0] filterVal,
    // demodulated level to receiver
    output logic rxOut
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_COUNT = 3'b010,
        ST_HOLD = 3'b100
    } usl_dem_e;
    localparam logic [4:0] BIT_LEN = 5'(usl_pkg::OVERSAMPLE);
    usl_dem_e state_reg;
    logic [FILTER_W-1:0] filt_reg;
    logic [4:0] hold_reg;
    logic prev_reg;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            prev_reg <= 1'b1;
        else
            prev_reg <= rxLine;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= ST_IDLE;
            filt_reg <= '0;
            hold_reg <= 5'h00;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    filt_reg <= filterVal;
                    if (prev_reg && !rxLine)
                        state_reg <= ST_COUNT;
                end
                ST_COUNT:
                begin
                    if (!prev_reg && rxLine)
                    begin
                        filt_reg <= filterVal;
                        state_reg <= ST_IDLE;
                    end
                    else if (filt_reg == '0)
                    begin
                        hold_reg <= BIT_LEN;
                        state_reg <= ST_HOLD;
                    end
                    else
                        filt_reg <= filt_reg - 1'b1;
                end
                ST_HOLD:
                begin
                    if (sampleTick)
                        hold_reg <= hold_reg - 5'h01;
                    // leave on the last tick, not one cycle after it
                    if (sampleTick && hold_reg == 5'h01)
                    begin
                        filt_reg <= filterVal;
                        state_reg <= ST_IDLE;
                    end
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    assign rxOut = (state_reg != ST_HOLD);
endmodule : usl_ir_demod

/* File: src/usl_line_modes.sv */
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module usl_line_modes #(
    parameter int MAX_ITER_W = 3,
    parameter int FILTER_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial core, same clock
    input wire logic sampleTick,
    input wire logic txBitStart,
    input wire logic coreTxd,
    input wire logic tx_empty_flag,
    input wire logic timeguardBusy,
    input wire usl_pkg::usl_rxev_s rxEv,
    input wire usl_pkg::usl_txev_s txEv,
    output logic coreRxd,
    output logic txAllow,
    output logic rxAllow,
    output logic txRepeat,
    output logic rxNackReq,
    output logic [10:0] clockRatio,
    // line pins
    input wire logic rxdPin,
    input wire logic riPin,
    input wire logic dsrPin,
    input wire logic dcdPin,
    input wire logic ctsPin,
    output logic txdPin,
    output logic rtsPin,
    output logic dtrPin
);
    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    generate
        if (MAX_ITER_W < 1 || MAX_ITER_W > 3)
            $error("MAX_ITER_W must be 1 to 3");
        if (FILTER_W < 1 || FILTER_W > 8)
            $error("FILTER_W must be 1 to 8");
    endgenerate

    function automatic logic mapped(input logic [7:0] a);
        mapped = a == usl_pkg::OFS_CR || a == usl_pkg::OFS_MR ||
            a == usl_pkg::OFS_CSR || a == usl_pkg::OFS_RHR ||
            a == usl_pkg::OFS_FIDI || a == usl_pkg::OFS_IF;
    endfunction : mapped

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] pinIn;
    logic [4:0] meta_reg;
    logic [4:0] pinS_reg;
    logic rxdS;
    logic [3:0] modemS;
    assign pinIn = {ctsPin, dcdPin, dsrPin, riPin, rxdPin};
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_sync
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    meta_reg[gi] <= 1'b1;
                    pinS_reg[gi] <= 1'b1;
                end
                else
                begin
                    meta_reg[gi] <= pinIn[gi];
                    pinS_reg[gi] <= meta_reg[gi];
                end
            end
        end
    endgenerate
    assign rxdS = pinS_reg[0];
    assign modemS = pinS_reg[4:1];

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [3:0] lineMode_reg;
    logic [1:0] chMode_reg;
    logic nack_inhibit_reg;
    logic limit_nack_enable_reg;
    logic [MAX_ITER_W-1:0] maxIter_reg;
    logic [10:0] ratio_reg;
    logic [FILTER_W-1:0] irFilter_reg;
    logic wrAcc;
    logic rdAcc;
    logic crWr;
    assign wrAcc = psel && penable && pwrite;
    assign rdAcc = psel && penable && !pwrite;
    assign crWr = wrAcc && paddr == usl_pkg::OFS_CR;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lineMode_reg <= 4'h0;
            chMode_reg <= 2'h0;
            nack_inhibit_reg <= 1'b0;
            limit_nack_enable_reg <= 1'b0;
            maxIter_reg <= '0;
        end
        else if (wrAcc && paddr == usl_pkg::OFS_MR)
        begin
            lineMode_reg <= pwdata[usl_pkg::MR_MODE_LSB +: 4];
            chMode_reg <= pwdata[usl_pkg::MR_CHMODE_LSB +: 2];
            nack_inhibit_reg <= pwdata[usl_pkg::MR_NACK_INHIBIT];
            limit_nack_enable_reg <= pwdata[usl_pkg::MR_LIMIT_NACK_ENABLE];
            maxIter_reg <= pwdata[usl_pkg::MR_MAXIT_LSB +: MAX_ITER_W];
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ratio_reg <= usl_pkg::FIDI_RST;
            irFilter_reg <= FILTER_W'(usl_pkg::IF_RST);
        end
        else if (wrAcc && paddr == usl_pkg::OFS_FIDI)
            ratio_reg <= pwdata[10:0];
        else if (wrAcc && paddr == usl_pkg::OFS_IF)
            irFilter_reg <= pwdata[FILTER_W-1:0];
    end
    assign clockRatio = ratio_reg;

    logic isoT0;
    logic isoT1;
    logic irMode;
    logic rs485;
    logic modem;
    assign isoT0 = lineMode_reg == usl_pkg::MODE_ISO_T0;
    assign isoT1 = lineMode_reg == usl_pkg::MODE_ISO_T1;
    assign irMode = lineMode_reg == usl_pkg::MODE_INFRA;
    assign rs485 = lineMode_reg == usl_pkg::MODE_RS485;
    assign modem = lineMode_reg == usl_pkg::MODE_MODEM;

    // ------------------------------------------------------------
    // receive error handling
    // ------------------------------------------------------------
    logic parErr;
    logic limitHit;
    logic sendNack;
    logic inhibit;
    logic [MAX_ITER_W-1:0] nackCnt_reg;
    logic [7:0] rxHold_reg;
    assign parErr = rxEv.valid && rxEv.parErr;
    assign inhibit = isoT0 && nack_inhibit_reg && parErr;
    assign limitHit = isoT0 && !nack_inhibit_reg && limit_nack_enable_reg && parErr &&
        nackCnt_reg >= maxIter_reg;
    assign sendNack = isoT0 && !nack_inhibit_reg && parErr && !limitHit;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            nackCnt_reg <= '0;
            rxNackReq <= 1'b0;
        end
        else
        begin
            rxNackReq <= sendNack;
            if (sendNack && limit_nack_enable_reg)
                nackCnt_reg <= nackCnt_reg + 1'b1;
            else if (rxEv.valid)
                nackCnt_reg <= '0;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rxHold_reg <= 8'h00;
        else if (rxEv.valid && !sendNack)
            rxHold_reg <= rxEv.data;
    end

    // ------------------------------------------------------------
    // transmit repetition
    // ------------------------------------------------------------
    logic [MAX_ITER_W-1:0] repCnt_reg;
    logic canRepeat;
    logic iterHit;
    assign canRepeat = isoT0 && maxIter_reg != '0 && repCnt_reg < maxIter_reg;
    assign iterHit = txEv.nack && canRepeat &&
        repCnt_reg + 1'b1 == maxIter_reg;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            repCnt_reg <= '0;
            txRepeat <= 1'b0;
        end
        else
        begin
            txRepeat <= txEv.nack && canRepeat;
            if (txEv.ack)
                repCnt_reg <= '0;
            else if (txEv.nack)
                repCnt_reg <= canRepeat ? repCnt_reg + 1'b1 : '0;
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    logic rxReady_reg;
    logic parity_error_flag_reg;
    logic nack_reg;
    logic iter_reg;
    logic [3:0] chg_reg;
    logic [3:0] modemPrev_reg;
    logic [3:0] chgSnap_reg;
    logic [3:0] chgSet;
    logic rhrRd;
    logic csrRd;
    assign rhrRd = rdAcc && paddr == usl_pkg::OFS_RHR;
    assign csrRd = rdAcc && paddr == usl_pkg::OFS_CSR;
    assign chgSet = modem ? (modemS ^ modemPrev_reg) : 4'h0;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rxReady_reg <= 1'b0;
            parity_error_flag_reg <= 1'b0;
            nack_reg <= 1'b0;
            iter_reg <= 1'b0;
        end
        else
        begin
            rxReady_reg <= (rxReady_reg && !rhrRd) ||
                (rxEv.valid && !sendNack && !inhibit);
            parity_error_flag_reg <= (parity_error_flag_reg && !(crWr && pwdata[usl_pkg::CR_RSTSTA]))
                || ((isoT0 || isoT1) && parErr);
            nack_reg <= (nack_reg && !(crWr && pwdata[usl_pkg::CR_CLEAR_NACK_CMD]))
                || inhibit;
            iter_reg <= (iter_reg && !(crWr && pwdata[usl_pkg::CR_RSTIT]))
                || iterHit || limitHit;
        end
    end

    // clear only what the read reported, so a change never gets lost
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            modemPrev_reg <= 4'hf;
            chg_reg <= 4'h0;
        end
        else
        begin
            modemPrev_reg <= modemS;
            chg_reg <= (chg_reg & ~(csrRd ? chgSnap_reg : 4'h0)) |
                chgSet;
        end
    end

    // ------------------------------------------------------------
    // modem and rs485 control pins
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            dtrPin <= usl_pkg::DTR_RST;
        else if (crWr && pwdata[usl_pkg::CR_DTR_DISABLE_CMD])
            dtrPin <= 1'b1;
        else if (crWr && pwdata[usl_pkg::CR_DTR_ENABLE_CMD])
            dtrPin <= 1'b0;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rtsPin <= 1'b1;
        else if (rs485)
            rtsPin <= !tx_empty_flag || timeguardBusy;
        else if (modem)
            rtsPin <= tx_empty_flag;
        else
            rtsPin <= 1'b1;
    end

    logic remote;
    assign remote = chMode_reg == usl_pkg::CH_REMOTE;
    assign txAllow = !remote && !(modem && modemS[3]);
    assign rxAllow = !remote;

    // ------------------------------------------------------------
    // infrared and channel routing
    // ------------------------------------------------------------
    logic irPulse;
    logic irRx;
    usl_ir_mod u_mod (
        .clk(clk),
        .reset_n(reset_n),
        .sampleTick(sampleTick),
        .bitStart(txBitStart && irMode),
        .txBit(coreTxd),
        .pulse(irPulse)
    );
    usl_ir_demod #(.FILTER_W(FILTER_W)) u_demod (
        .clk(clk),
        .reset_n(reset_n),
        .sampleTick(sampleTick),
        .rxLine(irMode ? rxdS : 1'b1),
        .filterVal(irFilter_reg),
        .rxOut(irRx)
    );

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            txdPin <= 1'b1;
            coreRxd <= 1'b1;
        end
        else
        begin
            case (chMode_reg)
                usl_pkg::CH_NORMAL:
                begin
                    txdPin <= irMode ? !irPulse : coreTxd;
                    coreRxd <= irMode ? irRx : rxdS;
                end
                usl_pkg::CH_ECHO:
                begin
                    txdPin <= rxdS;
                    coreRxd <= irMode ? irRx : rxdS;
                end
                usl_pkg::CH_LOCAL:
                begin
                    txdPin <= 1'b1;
                    coreRxd <= coreTxd;
                end
                usl_pkg::CH_REMOTE:
                begin
                    txdPin <= rxdS;
                    coreRxd <= 1'b1;
                end
                default:
                begin
                    txdPin <= 1'b1;
                    coreRxd <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // apb read path
    // ------------------------------------------------------------
    logic [31:0] csrVal;
    always_comb
    begin
        csrVal = 32'h0000_0000;
        csrVal[usl_pkg::CSR_RX_READY_FLAG] = rxReady_reg;
        csrVal[usl_pkg::CSR_PARITY_ERROR_FLAG] = parity_error_flag_reg;
        csrVal[usl_pkg::CSR_TX_EMPTY_FLAG] = tx_empty_flag;
        csrVal[usl_pkg::CSR_ITER] = iter_reg;
        csrVal[usl_pkg::CSR_NACK] = nack_reg;
        csrVal[usl_pkg::CSR_CTS_CHANGE_FLAG:usl_pkg::CSR_RI_CHANGE_FLAG] = chg_reg;
        csrVal[usl_pkg::CSR_CTS:usl_pkg::CSR_RI] = modemS;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata <= 32'h0000_0000;
            chgSnap_reg <= 4'h0;
        end
        else if (psel && !penable && !pwrite)
        begin
            chgSnap_reg <= chg_reg;
            case (paddr)
                usl_pkg::OFS_MR:
                    prdata <= {5'h00, 3'(maxIter_reg), 2'h0, limit_nack_enable_reg,
                        nack_inhibit_reg, 4'h0, chMode_reg, 10'h000, lineMode_reg};
                usl_pkg::OFS_CSR:
                    prdata <= csrVal;
                usl_pkg::OFS_RHR:
                    prdata <= {24'h000000, rxHold_reg};
                usl_pkg::OFS_FIDI:
                    prdata <= {21'h000000, ratio_reg};
                usl_pkg::OFS_IF:
                    prdata <= {24'h000000, 8'(irFilter_reg)};
                default:
                    prdata <= 32'h0000_0000;
            endcase
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
endmodule : usl_line_modes

/* File: tb/usl_line_checker.sv */
`timescale 1ns/1ps
module usl_line_checker (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    // core side
    input wire logic tx_empty_flag,
    input wire logic timeguardBusy,
    input wire usl_pkg::usl_rxev_s rxEv,
    input wire usl_pkg::usl_txev_s txEv,
    input wire logic rxAllow,
    input wire logic txRepeat,
    input wire logic rxNackReq,
    // pins
    input wire logic rxdPin,
    input wire logic txdPin,
    input wire logic rtsPin,
    input wire logic dtrPin
);
    logic [31:0] mr;
    wire wrAcc = psel && penable && pwrite;
    wire [3:0] md = mr[3:0];
    wire [1:0] ch = mr[15:14];
    // ----------------------------
    // mode register shadow
    // ----------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            mr <= 32'h0;
        else if (wrAcc && paddr == 8'h04)
            mr <= pwdata;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence crWr;
        wrAcc && paddr == 8'h00;
    endsequence
    sequence badChar;
        rxEv.valid && rxEv.parErr;
    endsequence
    // ----------------------------
    // assertions
    // ----------------------------
    nack_inhibit_a : assert property (
        mr[20] && rxEv.valid && rxEv.parErr |=> !rxNackReq)
        else $error("error bit sent while inhibited");
    nack_sent_a : assert property (
        md == 4'h4 && mr[21:20] == 2'h0 ##0 badChar |=> rxNackReq)
        else $error("no error bit after parity error");
    repeat_cause_a : assert property (
        txRepeat |-> $past(txEv.nack))
        else $error("repeat without nack");
    repeat_off_a : assert property (
        txEv.nack && mr[26:24] == 3'h0 |=> !txRepeat)
        else $error("repeat with zero limit");
    ack_stop_a : assert property (
        txEv.ack |=> !txRepeat)
        else $error("repeat after ack");
    rts_drive_a : assert property (
        md == 4'h1 && !tx_empty_flag |=> rtsPin)
        else $error("rts low while sending");
    rts_guard_a : assert property (
        md == 4'h1 && timeguardBusy |=> rtsPin)
        else $error("rts low in timeguard");
    dtr_off_a : assert property (
        crWr ##0 pwdata[17] |=> dtrPin)
        else $error("dtr not high");
    dtr_on_a : assert property (
        crWr ##0 pwdata[16] && !pwdata[17] |=> !dtrPin)
        else $error("dtr not low");
    echo_path_a : assert property (
        md == 4'h0 && ch == 2'h1 && $past(ch, 3) == 2'h1
        |-> txdPin == $past(rxdPin, 3))
        else $error("echo mismatch");
    local_idle_a : assert property (
        ch == 2'h2 && $past(ch) == 2'h2 |-> txdPin)
        else $error("txd low in local loop");
    remote_rx_a : assert property (
        ch == 2'h3 |-> !rxAllow)
        else $error("receiver on in remote loop");
endmodule : usl_line_checker

/* File: tb/usl_far_end.sv */
`timescale 1ns/1ps
module usl_far_end (
    // clock
    input wire logic clk,
    // levels asked for by the bench
    input wire logic rxdSet,
    input wire logic ctsSet,
    // remote line pins
    output logic rxdPin,
    output logic riPin,
    output logic dsrPin,
    output logic dcdPin,
    output logic ctsPin
);
    initial {rxdPin, ctsPin} = 2'h3;
    // remote lines change just after an edge
    always @(posedge clk)
    begin
        rxdPin <= rxdSet;
        ctsPin <= ctsSet;
    end
    assign {riPin, dsrPin, dcdPin} = 3'h7;
endmodule : usl_far_end

/* File: tb/tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
 $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic sampleTick, txBitStart, coreTxd, tx_empty_flag, timeguardBusy;
    logic coreRxd, txAllow, rxAllow, txRepeat, rxNackReq, rxdSet, ctsSet;
    logic txdPin, rtsPin, dtrPin, rxdPin, riPin, dsrPin, dcdPin, ctsPin;
    logic [10:0] clockRatio;
    usl_pkg::usl_rxev_s rxEv;
    usl_pkg::usl_txev_s txEv;
    int failures = 0, checks = 0, cyc = 0, n;
    // chmode, rxd level, expected txd
    logic [3:0] rows [5] = '{4'h1, 4'h4, 4'h7, 4'h9, 4'hc};
    logic [1:0] evs [5] = '{2'h2, 2'h1, 2'h2, 2'h2, 2'h2};
    logic [4:0] reps = 5'b10110;
    usl_line_modes i_usl_line_modes (.*);
    usl_far_end i_usl_far_end (.*);
    initial
    begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            failures++;
            give_verdict();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
        @(negedge clk);
    endtask : apb
    task automatic give_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, rxEv, txEv} = '0;
        {sampleTick, txBitStart, tx_empty_flag, timeguardBusy, reset_n} = '0;
        {coreTxd, rxdSet, ctsSet} = 3'h7;
        repeat (6) @(posedge clk);
        `CHK(dtrPin, 1'b1)
        `CHK(clockRatio, 11'h174)
        reset_n <= 1;
        foreach (rows[i])
        begin
            apb(1, 8'h04, {16'h0, rows[i][3:2], 14'h0});
            @(posedge clk) rxdSet <= rows[i][1];
            repeat (8) @(negedge clk);
            `CHK(txdPin, rows[i][0])
        end
        `CHK({rxAllow, txAllow}, 2'h0)
        apb(0, 8'h30, 0);
        `CHK({err, rd}, 33'h100000000)
        $display("test modes done");
        apb(1, 8'h00, 32'h10000);
        `CHK(dtrPin, 1'b0)
        apb(1, 8'h00, 32'h30000);
        `CHK(dtrPin, 1'b1)
        apb(1, 8'h04, 32'h1);
        @(posedge clk) {tx_empty_flag, timeguardBusy} <= 2'h0;
        repeat (2) @(negedge clk);
        `CHK(rtsPin, 1'b1)
        @(posedge clk) {tx_empty_flag, timeguardBusy} <= 2'h3;
        repeat (2) @(negedge clk);
        `CHK(rtsPin, 1'b1)
        @(posedge clk) timeguardBusy <= 0;
        repeat (2) @(negedge clk);
        `CHK(rtsPin, 1'b0)
        $display("dtr and rts done");
        apb(1, 8'h04, 32'h3);
        @(posedge clk) {ctsSet, rxdSet} <= 2'h1;
        repeat (6) @(posedge clk);
        apb(0, 8'h14, 0);
        `CHK(rd[19], 1'b1)
        apb(0, 8'h14, 0);
        `CHK({rd[19], txAllow}, 2'h1)
        @(posedge clk) ctsSet <= 1;
        repeat (6) @(negedge clk);
        `CHK(txAllow, 1'b0)
        $display("modem done");
        for (int k = 0; k < 2; k++)
        begin
            apb(1, 8'h04, k ? 32'h4 : 32'h100004);
            @(posedge clk) rxEv <= {1'b1, 1'b1, 8'ha5};
            @(posedge clk) rxEv <= '0;
            @(negedge clk);
            `CHK(rxNackReq, k[0])
            apb(0, 8'h14, 0);
            `CHK({rd[13], rd[0]}, {~k[0], 1'b0})
            apb(0, 8'h18, 0);
            `CHK(rd[7:0], 8'ha5)
            apb(1, 8'h00, 32'h4000);
        end
        apb(0, 8'h14, 0);
        `CHK(rd[13], 1'b0)
        apb(1, 8'h04, 32'h2000004);
        foreach (evs[i])
        begin
            @(posedge clk) txEv <= evs[i];
            @(posedge clk) txEv <= '0;
            @(negedge clk);
            `CHK(txRepeat, reps[4-i])
        end
        apb(0, 8'h14, 0);
        `CHK(rd[10], 1'b1)
        apb(1, 8'h00, 32'h2000);
        apb(0, 8'h14, 0);
        `CHK(rd[10], 1'b0)
        apb(1, 8'h04, 32'h1200004);
        repeat (2)
        begin
            @(posedge clk) rxEv <= {1'b1, 1'b1, 8'h3c};
            @(posedge clk) rxEv <= '0;
        end
        apb(0, 8'h14, 0);
        `CHK({rd[10], rd[0]}, 2'h3)
        apb(0, 8'h18, 0);
        `CHK(rd[7:0], 8'h3c)
        apb(1, 8'h00, 32'h100);
        apb(1, 8'h04, 32'h6);
        apb(0, 8'h14, 0);
        `CHK(rd[7], 1'b0)
        @(posedge clk) rxEv <= {1'b1, 1'b1, 8'h00};
        @(posedge clk) rxEv <= '0;
        apb(0, 8'h14, 0);
        `CHK(rd[7], 1'b1)
        $display("smart card done");
        apb(1, 8'h40, 32'h1);
        `CHK(clockRatio, 11'h001)
        apb(1, 8'h04, 32'h8);
        @(posedge clk) {sampleTick, coreTxd, txBitStart} <= 3'h5;
        @(posedge clk) txBitStart <= 0;
        n = 0;
        repeat (20) @(negedge clk) n += !txdPin;
        `CHK(n, 3)
        apb(1, 8'h4c, 32'h4);
        n = 0;
        @(posedge clk) rxdSet <= 0;
        @(posedge clk) rxdSet <= 1;
        repeat (4) @(posedge clk);
        rxdSet <= 0;
        repeat (40) @(negedge clk) n += !coreRxd;
        `CHK(n, 16)
        $display("infrared done");
        give_verdict();
    end
endmodule : tb
bind usl_line_modes usl_line_checker i_usl_line_checker (.*);
